// >>> core/wdc_defines.svh
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH

// register map
`define WDC_ADDR_W        8
`define WDC_CTRL_ADDR     8'h00

// control field positions
`define WDC_CE_BIT        4
`define WDC_ON_BIT        3
`define WDC_SEL_MSB       2
`define WDC_SEL_LSB       0
`define WDC_RES_MSB       7
`define WDC_RES_LSB       5

// reset values
`define WDC_ON_RESET      1'b0
`define WDC_SEL_RESET     3'h0
`define WDC_RDATA_RESET   8'h00

// timing
`define WDC_CE_CYCLES     3'h4
`define WDC_BASE_TICKS    16384
`define WDC_OSC_FREQ_HZ   1000000
`define WDC_CNT_W         22

// fuse level: unprogrammed reads one
`define WDC_FUSE_PROG     1'b0

`endif

// >>> core/wdc_pkg.sv
package wdc_pkg;

  typedef enum logic {
    WDC_LEVEL1 = 1'b0,
    WDC_LEVEL2 = 1'b1
  } wdc_level_t;

  typedef logic [2:0] wdc_sel_t;

  typedef logic [7:0] wdc_byte_t;

endpackage : wdc_pkg

// >>> core/wdc_watchdog.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "wdc_defines.svh"
module wdc_watchdog #(
  parameter int BASE_TICKS = `WDC_BASE_TICKS
) (
  input  wire logic                   clock_i,
  input  wire logic                   rstn_i,
  input  wire logic                   ce_i,
  input  wire logic [`WDC_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  input  wire logic                   wdt_osc_i,
  input  wire logic                   restart_instruction_i,
  input  wire logic                   safety_level_fuse_i,
  output logic                        wdt_reset_o,
  output logic                        wdt_running_o
);

  function automatic logic hits_ctrl(input logic             strobe,
                                     input logic [`WDC_ADDR_W-1:0] addr);
    return strobe && (addr == `WDC_CTRL_ADDR);
  endfunction : hits_ctrl

  function automatic logic [`WDC_CNT_W-1:0] timeout_limit(input wdc_pkg::wdc_sel_t sel);
    return `WDC_CNT_W'(BASE_TICKS) << sel;
  endfunction : timeout_limit

  wdc_pkg::wdc_level_t level;
  logic                ctrl_wr;
  logic                ctrl_rd;
  logic                w_ce;
  logic                w_on;
  wdc_pkg::wdc_sel_t   w_sel;

  // control state
  logic                on_reg;
  logic                next_on_reg;
  wdc_pkg::wdc_sel_t   sel;
  wdc_pkg::wdc_sel_t   next_sel;
  logic [2:0]          ce_cnt;
  logic [2:0]          next_ce_cnt;
  logic                change_enable_bit;
  logic                watchdog_on_bit;

  // read path
  logic [7:0]          next_rdata;

  // oscillator sampling
  logic                osc_meta;
  logic                osc_sync;
  logic                osc_last;
  logic                osc_tick;

  // time-out counter
  logic [`WDC_CNT_W-1:0] wdt_count;
  logic [`WDC_CNT_W-1:0] next_wdt_count;
  logic [`WDC_CNT_W-1:0] limit;
  logic                  next_wdt_reset;
  logic                  expire;

  // fuse decode
  assign level = (safety_level_fuse_i == `WDC_FUSE_PROG) ?
                 wdc_pkg::WDC_LEVEL2 : wdc_pkg::WDC_LEVEL1;

  assign ctrl_wr = hits_ctrl(wr_i, addr_i);
  assign ctrl_rd = hits_ctrl(rd_i, addr_i);
  assign w_ce    = wdata_i[`WDC_CE_BIT];
  assign w_on    = wdata_i[`WDC_ON_BIT];
  assign w_sel   = wdata_i[`WDC_SEL_MSB:`WDC_SEL_LSB];

  assign change_enable_bit = (ce_cnt != 3'h0);
  // level 2 forces the watchdog on
  assign watchdog_on_bit = on_reg || (level == wdc_pkg::WDC_LEVEL2);
  assign wdt_running_o   = watchdog_on_bit;

  // control register next values
  always_comb begin
    next_on_reg = on_reg;
    next_sel    = sel;
    next_ce_cnt = (ce_cnt != 3'h0) ? ce_cnt - 3'h1 : 3'h0;
    if (ctrl_wr) begin
      if (change_enable_bit) begin
        // second step of the timed sequence
        next_sel = w_sel;
        if (level == wdc_pkg::WDC_LEVEL1) begin
          next_on_reg = w_on;
        end
        // level 2 ignores the on bit, so no disable
        if (w_ce && w_on) begin
          next_ce_cnt = `WDC_CE_CYCLES;
        end else begin
          next_ce_cnt = 3'h0;
        end
      end else begin
        // ordinary write: enable only, select untouched
        next_on_reg = on_reg || w_on;
        if (w_ce && w_on) begin
          next_ce_cnt = `WDC_CE_CYCLES;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      on_reg <= `WDC_ON_RESET;
      sel    <= `WDC_SEL_RESET;
      ce_cnt <= 3'h0;
    end else if (ce_i) begin
      on_reg <= next_on_reg;
      sel    <= next_sel;
      ce_cnt <= next_ce_cnt;
    end
  end

  // read data, valid the cycle after the strobe only
  always_comb begin
    next_rdata = 8'h00;
    if (ctrl_rd) begin
      next_rdata[`WDC_RES_MSB:`WDC_RES_LSB] = 3'h0;
      next_rdata[`WDC_CE_BIT]               = change_enable_bit;
      next_rdata[`WDC_ON_BIT]               = watchdog_on_bit;
      next_rdata[`WDC_SEL_MSB:`WDC_SEL_LSB] = sel;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `WDC_RDATA_RESET;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

  // oscillator synchroniser and rising edge detect
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
    end else if (ce_i) begin
      osc_meta <= wdt_osc_i;
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end

  assign osc_tick = osc_sync && !osc_last;

  // time-out counter and expiry pulse
  assign limit  = timeout_limit(sel);
  assign expire = watchdog_on_bit && osc_tick &&
                  ((wdt_count + `WDC_CNT_W'(1)) >= limit);

  always_comb begin
    next_wdt_count = wdt_count;
    next_wdt_reset = 1'b0;
    if (!watchdog_on_bit || restart_instruction_i) begin
      next_wdt_count = '0;
    end else if (expire) begin
      next_wdt_count = '0;
      next_wdt_reset = 1'b1;
    end else if (osc_tick) begin
      next_wdt_count = wdt_count + `WDC_CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdt_count   <= '0;
      wdt_reset_o <= 1'b0;
    end else if (ce_i) begin
      wdt_count   <= next_wdt_count;
      wdt_reset_o <= next_wdt_reset;
    end else begin
      wdt_reset_o <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_open;
    ce_i && ctrl_wr && w_ce && w_on && !change_enable_bit;
  endsequence

  sequence s_quiet4;
    (ce_i && !wr_i)[*4];
  endsequence

  sequence s_second;
    ce_i && ctrl_wr && !w_ce && change_enable_bit;
  endsequence

  property p_res_zero;
    ce_i && rd_i |=> rdata_o[`WDC_RES_MSB:`WDC_RES_LSB] == 3'h0;
  endproperty
  a_res_zero: assert property (p_res_zero)
    else $error("reserved bits read non-zero");

  property p_ce_selfclear;
    s_open ##1 s_quiet4 |=> !change_enable_bit;
  endproperty
  a_ce_selfclear: assert property (p_ce_selfclear)
    else $error("change enable did not clear after four cycles");

  property p_ce_holds;
    s_open ##1 (ce_i && !wr_i) |-> change_enable_bit ##1 change_enable_bit;
  endproperty
  a_ce_holds: assert property (p_ce_holds)
    else $error("change enable cleared too early");

  property p_free_enable;
    ce_i && ctrl_wr && w_on && level == wdc_pkg::WDC_LEVEL1 |=> watchdog_on_bit;
  endproperty
  a_free_enable: assert property (p_free_enable)
    else $error("enable write not honoured");

  property p_no_plain_disable;
    ce_i && ctrl_wr && !change_enable_bit && watchdog_on_bit |=> watchdog_on_bit;
  endproperty
  a_no_plain_disable: assert property (p_no_plain_disable)
    else $error("watchdog disabled without change enable");

  property p_sel_locked;
    ce_i && !change_enable_bit |=> $stable(sel);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("time-out changed without change enable");

  property p_second_l1;
    s_second and level == wdc_pkg::WDC_LEVEL1
      |=> on_reg == $past(w_on) && sel == $past(w_sel);
  endproperty
  a_second_l1: assert property (p_second_l1)
    else $error("second write not applied in level 1");

  property p_l2_on;
    level == wdc_pkg::WDC_LEVEL2 && ce_i && ctrl_rd
      |-> watchdog_on_bit ##1 rdata_o[`WDC_ON_BIT];
  endproperty
  a_l2_on: assert property (p_l2_on)
    else $error("level 2 on bit not read as one");

  property p_l2_no_disable;
    s_second and level == wdc_pkg::WDC_LEVEL2 && !w_on |=> watchdog_on_bit;
  endproperty
  a_l2_no_disable: assert property (p_l2_no_disable)
    else $error("level 2 watchdog disabled");

  property p_l2_sel;
    s_second and level == wdc_pkg::WDC_LEVEL2 |=> sel == $past(w_sel);
  endproperty
  a_l2_sel: assert property (p_l2_sel)
    else $error("level 2 select not applied");

  property p_expire;
    ce_i && watchdog_on_bit && osc_tick && !restart_instruction_i &&
      (wdt_count + `WDC_CNT_W'(1)) == limit |=> wdt_reset_o && wdt_count == '0;
  endproperty
  a_expire: assert property (p_expire)
    else $error("time-out not taken at selected count");

  property p_restart;
    ce_i && (restart_instruction_i || !watchdog_on_bit) |=> wdt_count == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("counter not cleared");

  property p_pulse_one;
    wdt_reset_o |=> !wdt_reset_o;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("reset pulse longer than one cycle");

  property p_pulse_cause;
    wdt_reset_o |-> $past(expire) && $past(ce_i);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("reset pulse without expiry");

  property p_open;
    s_open |=> change_enable_bit && watchdog_on_bit;
  endproperty
  a_open: assert property (p_open)
    else $error("opening write did not open the window");

  property p_ce_alone;
    ce_i && ctrl_wr && w_ce && !w_on && !change_enable_bit |=> !change_enable_bit;
  endproperty
  a_ce_alone: assert property (p_ce_alone)
    else $error("window opened without the on bit");

  property p_window_close;
    s_second |=> !change_enable_bit;
  endproperty
  a_window_close: assert property (p_window_close)
    else $error("window still open after second write");

  property p_late_write;
    s_open ##1 s_quiet4 ##1 (ce_i && ctrl_wr) |=> $stable(sel);
  endproperty
  a_late_write: assert property (p_late_write)
    else $error("late second write changed the time-out");

  property p_tick;
    ce_i && watchdog_on_bit && osc_tick && !restart_instruction_i && !expire
      |=> wdt_count == $past(wdt_count) + `WDC_CNT_W'(1);
  endproperty
  a_tick: assert property (p_tick)
    else $error("counter missed an oscillator tick");

  property p_rdata_idle;
    ce_i && !ctrl_rd |=> rdata_o == `WDC_RDATA_RESET;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // read data stand one cycle
    else $error("read data outside the read cycle");

  property p_freeze;
    !ce_i |=> $stable(on_reg) && $stable(sel) && $stable(ce_cnt) &&
              $stable(wdt_count) && $stable(rdata_o) && !wdt_reset_o;
  endproperty
  a_freeze: assert property (p_freeze) // clock enable low freezes state
    else $error("state moved while clock enable low");

endmodule : wdc_watchdog

// >>> testbench/watchdog_timed_config_tb.sv
`timescale 1ns/1ns
module watchdog_timed_config_tb;
  localparam int BASE = 4;
  logic       clock_i  = 1'b0;
  logic       rstn_i   = 1'b0;
  logic [7:0] addr_i   = 8'h00;
  logic [7:0] wdata_i  = 8'h00;
  logic       wr_i     = 1'b0;
  logic       rd_i     = 1'b0;
  logic [7:0] rdata_o;
  logic       osc      = 1'b0;
  logic       restart  = 1'b0;
  logic       fuse     = 1'b1;
  logic       ce       = 1'b1;
  logic       wdt_reset_o;
  logic       wdt_running_o;
  logic       pend     = 1'b0;
  logic [7:0] pend_exp = 8'h00;
  logic [7:0] n_pulse  = 8'h00;
  logic [7:0] base_pulse;
  int         n_errors = 0;
  int         check_count = 0;

  always #5 clock_i = ~clock_i;

  wdc_watchdog #(.BASE_TICKS(BASE)) wdc_watchdog_i (
    .clock_i               (clock_i),
    .rstn_i                (rstn_i),
    .ce_i                  (ce),
    .addr_i                (addr_i),
    .wdata_i               (wdata_i),
    .wr_i                  (wr_i),
    .rd_i                  (rd_i),
    .rdata_o               (rdata_o),
    .wdt_osc_i             (osc),
    .restart_instruction_i (restart),
    .safety_level_fuse_i   (fuse),
    .wdt_reset_o           (wdt_reset_o),
    .wdt_running_o         (wdt_running_o)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // read data stand in the cycle after the read strobe
  always @(negedge clock_i) begin
    if (pend) check(rdata_o, pend_exp);
    pend <= 1'b0;
  end

  always @(posedge clock_i) begin
    if (wdt_reset_o === 1'b1) n_pulse <= n_pulse + 8'h01;
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    wr_i    <= 1'b1;
    rd_i    <= 1'b0;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    rd_i   <= 1'b1;
    wr_i   <= 1'b0;
    addr_i <= a;
    @(posedge clock_i);
    pend     <= 1'b1;
    pend_exp <= exp;
  endtask : rd

  task idle(input int n);
    wr_i    <= 1'b0;
    rd_i    <= 1'b0;
    restart <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask : idle

  task run_is(input logic exp);
    idle(0);
    @(negedge clock_i);
    check({7'h00, wdt_running_o}, {7'h00, exp});
    @(posedge clock_i);
  endtask : run_is

  task set_cfg(input logic [7:0] d);
    wr(8'h00, 8'h18);
    wr(8'h00, d);
  endtask : set_cfg

  task kick;
    idle(0);
    restart <= 1'b1;
    @(posedge clock_i);
    restart <= 1'b0;
  endtask : kick

  // oscillator is much slower than the system clock
  task ticks(input int n);
    idle(0);
    repeat (n) begin
      osc <= 1'b1;
      repeat (4) @(posedge clock_i);
      osc <= 1'b0;
      repeat (6) @(posedge clock_i);
    end
  endtask : ticks

  initial begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    rd(8'h00, 8'h00);
    run_is(1'b0);
    wr(8'h00, 8'he8);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h0f);
    rd(8'h00, 8'h08);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h00, 8'h13);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    for (int i = 0; i < 4; i++) begin
      rd(8'h00, 8'h18);
    end
    rd(8'h00, 8'h08);
    set_cfg(8'h05);
    rd(8'h00, 8'h05);
    run_is(1'b0);
    wr(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    idle(3);
    wr(8'h00, 8'h0b);
    rd(8'h00, 8'h0b);
    wr(8'h00, 8'h18);
    idle(4);
    wr(8'h00, 8'h02);
    rd(8'h00, 8'h0b);
    for (int s = 0; s < 3; s++) begin
      set_cfg({5'h01, s[2:0]});
      kick();
      base_pulse = n_pulse;
      ticks((BASE << s) - 1);
      check(n_pulse, base_pulse);
      ticks(1);
      check(n_pulse, base_pulse + 8'h01);
    end
    set_cfg(8'h08);
    kick();
    base_pulse = n_pulse;
    ticks(3);
    kick();
    ticks(3);
    check(n_pulse, base_pulse);
    set_cfg(8'h00);
    wr(8'h00, 8'h08);
    ticks(3);
    check(n_pulse, base_pulse);
    set_cfg(8'h00);
    rd(8'h00, 8'h00);
    fuse <= 1'b0;
    run_is(1'b1);
    rd(8'h00, 8'h08);
    set_cfg(8'h03);
    rd(8'h00, 8'h0b);
    run_is(1'b1);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h0b);
    ce <= 1'b0;
    wr(8'h00, 8'h18);
    ce <= 1'b1;
    rd(8'h00, 8'h0b);
    idle(1);
    rstn_i <= 1'b0;
    idle(2);
    rstn_i <= 1'b1;
    idle(1);
    rd(8'h00, 8'h08);
    idle(2);
    end_sim();
  end
endmodule : watchdog_timed_config_tb
